// [hw/msif_irq_flags.sv]
`timescale 1ns/10ps
`include "msif_params.svh"
// Summary of operation
// - bit0 sets on conversion or sweep done
// - idle sequencer never sets bit0
// - bit1 sets on any result refresh
// - results refresh per conversion or sweep
// - bit1 clears after flags then both statuses
// - bit2 sets on overwritten result, read clears
// - bit3 input event, clears after statuses read
// - bit4 event missed, clears like bit3
// - bit5 sets on driver overcurrent trip
// - bit5 clears after flags then both statuses
// - local high-limit exceed sets field bit2
// - local below low-limit sets field bit1
// - new local result sets field bit0
// - remote a flags in bits 11:9
// - remote b flags in bits 14:12
// - bit15 sets on port supply low
// - read-only identification value
// - per-port result status, mask-independent
// - temperatures 12-bit signed compare
module msif_irq_flags #(
  parameter int PORTS = `MSIF_PORTS
)
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire msif_pkg::msif_mode_type i_conv_mode,
  input wire logic i_conv_done,
  input wire logic i_sweep_done,
  input wire logic [PORTS-1:0] i_port_sample_done,
  input wire logic [PORTS-1:0] i_port_unread,
  input wire logic i_input_event,
  input wire logic i_input_status_overwrite,
  input wire logic i_overcurrent_trip,
  input wire logic i_supply_low,
  input wire logic [11:0] i_local_temp,
  input wire logic i_local_temp_valid,
  input wire logic [11:0] i_local_high_limit,
  input wire logic [11:0] i_local_low_limit,
  input wire logic [11:0] i_remote_a_temp,
  input wire logic i_remote_a_valid,
  input wire logic [11:0] i_remote_a_high_limit,
  input wire logic [11:0] i_remote_a_low_limit,
  input wire logic [11:0] i_remote_b_temp,
  input wire logic i_remote_b_valid,
  input wire logic [11:0] i_remote_b_high_limit,
  input wire logic [11:0] i_remote_b_low_limit,
  input wire logic i_flags_read,
  input wire logic i_result_status_lo_read,
  input wire logic i_result_status_hi_read,
  input wire logic i_input_status_lo_read,
  input wire logic i_input_status_hi_read,
  input wire logic i_ocur_status_lo_read,
  input wire logic i_ocur_status_hi_read,
  output logic [15:0] o_event_flags,
  output logic [15:0] o_part_identification,
  output logic [PORTS-1:0] o_result_port_status
);
  // ==================================================
  // synchronisers for the analog monitor pins
  logic ocur_meta_q;
  logic ocur_sync_q;
  logic supply_meta_q;
  logic supply_sync_q;
  logic supply_prev_q;
  logic ocur_prev_q;
  // sample the asynchronous comparator outputs twice
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ocur_meta_q <= 1'b0;
      ocur_sync_q <= 1'b0;
      supply_meta_q <= 1'b0;
      supply_sync_q <= 1'b0;
      ocur_prev_q <= 1'b0;
      supply_prev_q <= 1'b0;
    end
    else
    begin
      ocur_meta_q <= i_overcurrent_trip;
      ocur_sync_q <= ocur_meta_q;
      supply_meta_q <= i_supply_low;
      supply_sync_q <= supply_meta_q;
      ocur_prev_q <= ocur_sync_q;
      supply_prev_q <= supply_sync_q;
    end
  end

  // ==================================================
  // two-register clear sequencer
  // a flag read arms it; both status reads then fire the clear
  function automatic msif_pkg::msif_clr_type clr_next(
    input msif_pkg::msif_clr_type st,
    input logic flag_rd,
    input logic lo_rd,
    input logic hi_rd
  );
    msif_pkg::msif_clr_type nx;
    nx = st;
    if (flag_rd)
      nx = msif_pkg::MSIF_CLR_ARMED;
    else
    begin
      unique case (st)
        msif_pkg::MSIF_CLR_IDLE: nx = st;
        msif_pkg::MSIF_CLR_ARMED:
          if (lo_rd && hi_rd)
            nx = msif_pkg::MSIF_CLR_IDLE;
          else if (lo_rd)
            nx = msif_pkg::MSIF_CLR_HALF_A;
          else if (hi_rd)
            nx = msif_pkg::MSIF_CLR_HALF_B;
        msif_pkg::MSIF_CLR_HALF_A:
          if (hi_rd)
            nx = msif_pkg::MSIF_CLR_IDLE;
        msif_pkg::MSIF_CLR_HALF_B:
          if (lo_rd)
            nx = msif_pkg::MSIF_CLR_IDLE;
      endcase
    end
    return nx;
  endfunction : clr_next

  // clear fires on the read that completes the pair
  function automatic logic clr_fire(
    input msif_pkg::msif_clr_type st,
    input logic flag_rd,
    input logic lo_rd,
    input logic hi_rd
  );
    logic f;
    f = 1'b0;
    if (!flag_rd)
      f = (st == msif_pkg::MSIF_CLR_ARMED && lo_rd && hi_rd) ||
        (st == msif_pkg::MSIF_CLR_HALF_A && hi_rd) ||
        (st == msif_pkg::MSIF_CLR_HALF_B && lo_rd);
    return f;
  endfunction : clr_fire

  msif_pkg::msif_clr_type res_clr_q;
  msif_pkg::msif_clr_type evt_clr_q;
  msif_pkg::msif_clr_type ocr_clr_q;
  wire logic res_clear = clr_fire(res_clr_q, i_flags_read,
    i_result_status_lo_read, i_result_status_hi_read);
  wire logic evt_clear = clr_fire(evt_clr_q, i_flags_read,
    i_input_status_lo_read, i_input_status_hi_read);
  wire logic ocr_clear = clr_fire(ocr_clr_q, i_flags_read,
    i_ocur_status_lo_read, i_ocur_status_hi_read);

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      res_clr_q <= msif_pkg::MSIF_CLR_IDLE;
      evt_clr_q <= msif_pkg::MSIF_CLR_IDLE;
      ocr_clr_q <= msif_pkg::MSIF_CLR_IDLE;
    end
    else
    begin
      res_clr_q <= clr_next(res_clr_q, i_flags_read,
        i_result_status_lo_read, i_result_status_hi_read);
      evt_clr_q <= clr_next(evt_clr_q, i_flags_read,
        i_input_status_lo_read, i_input_status_hi_read);
      ocr_clr_q <= clr_next(ocr_clr_q, i_flags_read,
        i_ocur_status_lo_read, i_ocur_status_hi_read);
    end
  end

  // ==================================================
  // temperature channels
  msif_temp_if t_local();
  msif_temp_if t_ra();
  msif_temp_if t_rb();
  assign t_local.valid = i_local_temp_valid;
  assign t_local.value = msif_pkg::msif_temp_type'(i_local_temp);
  assign t_local.high_limit = msif_pkg::msif_temp_type'(i_local_high_limit);
  assign t_local.low_limit = msif_pkg::msif_temp_type'(i_local_low_limit);
  assign t_ra.valid = i_remote_a_valid;
  assign t_ra.value = msif_pkg::msif_temp_type'(i_remote_a_temp);
  assign t_ra.high_limit = msif_pkg::msif_temp_type'(i_remote_a_high_limit);
  assign t_ra.low_limit = msif_pkg::msif_temp_type'(i_remote_a_low_limit);
  assign t_rb.valid = i_remote_b_valid;
  assign t_rb.value = msif_pkg::msif_temp_type'(i_remote_b_temp);
  assign t_rb.high_limit = msif_pkg::msif_temp_type'(i_remote_b_high_limit);
  assign t_rb.low_limit = msif_pkg::msif_temp_type'(i_remote_b_low_limit);
  msif_temp_cmp u_cmp_local (.t(t_local));
  msif_temp_cmp u_cmp_ra (.t(t_ra));
  msif_temp_cmp u_cmp_rb (.t(t_rb));

  // ==================================================
  // event decode
  // sequencer completion; idle mode gives nothing
  wire logic conv_evt = (i_conv_mode == msif_pkg::MSIF_SINGLE_CONV)
    ? i_conv_done
    : ((i_conv_mode != msif_pkg::MSIF_IDLE) && i_sweep_done);
  // result refresh happens on the same completion strobe
  wire logic [PORTS-1:0] refresh = i_port_sample_done &
    {PORTS{conv_evt}};
  wire logic res_evt = |refresh;
  wire logic miss_evt = |(refresh & i_port_unread);
  wire logic ocr_evt = ocur_sync_q && !ocur_prev_q;
  wire logic sup_evt = supply_sync_q && !supply_prev_q;

  logic [15:0] set_vec;
  logic [15:0] clr_vec;
  // collect sets and clear sources per bit
  always_comb
  begin
    set_vec = 16'h0000;
    set_vec[`MSIF_BIT_CONV_DONE] = conv_evt;
    set_vec[`MSIF_BIT_RES_READY] = res_evt;
    set_vec[`MSIF_BIT_RES_MISSED] = miss_evt;
    set_vec[`MSIF_BIT_EVT_READY] = i_input_event;
    set_vec[`MSIF_BIT_EVT_MISSED] = i_input_status_overwrite;
    set_vec[`MSIF_BIT_OVERCURRENT] = ocr_evt;
    set_vec[`MSIF_LSB_LOCAL_TEMP +: 3] = t_local.events;
    set_vec[`MSIF_LSB_REMOTE_A +: 3] = t_ra.events;
    set_vec[`MSIF_LSB_REMOTE_B +: 3] = t_rb.events;
    set_vec[`MSIF_BIT_SUPPLY_LOW] = sup_evt;
    clr_vec = {16{i_flags_read}};
    clr_vec[`MSIF_BIT_RES_READY] = res_clear;
    clr_vec[`MSIF_BIT_EVT_READY] = evt_clear;
    clr_vec[`MSIF_BIT_EVT_MISSED] = evt_clear;
    clr_vec[`MSIF_BIT_OVERCURRENT] = ocr_clear;
  end

  // ==================================================
  // sticky flag and status registers
  logic [15:0] flags_q;
  logic [15:0] flags_d;
  logic [PORTS-1:0] rstat_q;
  logic [PORTS-1:0] rstat_d;
  // set has priority over clear
  assign flags_d = (flags_q & ~clr_vec) | set_vec;
  assign rstat_d = (rstat_q & ~{PORTS{res_clear}}) | refresh;

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      flags_q <= `MSIF_FLAGS_RESET;
      rstat_q <= '0;
    end
    else
    begin
      flags_q <= flags_d;
      rstat_q <= rstat_d;
    end
  end

  assign o_event_flags = flags_q;
  assign o_result_port_status = rstat_q;
  assign o_part_identification = `MSIF_PART_ID;
endmodule : msif_irq_flags

// [hw/msif_params.svh]
`ifndef MSIF_PARAMS_SVH
`define MSIF_PARAMS_SVH
// flag register bit positions
`define MSIF_BIT_CONV_DONE 0
`define MSIF_BIT_RES_READY 1
`define MSIF_BIT_RES_MISSED 2
`define MSIF_BIT_EVT_READY 3
`define MSIF_BIT_EVT_MISSED 4
`define MSIF_BIT_OVERCURRENT 5
`define MSIF_LSB_LOCAL_TEMP 6
`define MSIF_LSB_REMOTE_A 9
`define MSIF_LSB_REMOTE_B 12
`define MSIF_BIT_SUPPLY_LOW 15
// position inside a three-bit temperature field
`define MSIF_TF_NEW 0
`define MSIF_TF_LOW 1
`define MSIF_TF_HIGH 2
// register widths and counts
`define MSIF_REG_W 16
`define MSIF_TEMP_W 12
`define MSIF_PORTS 12
`define MSIF_FLAGS_RESET 16'h0000
// identification value, arbitrary
`define MSIF_PART_ID 16'h5A31
`endif

// [hw/msif_pkg.sv]
package msif_pkg;
  // sequencer modes of the converter
  typedef enum logic [1:0] {
    MSIF_IDLE,
    MSIF_SINGLE_CONV,
    MSIF_SINGLE_SWEEP,
    MSIF_CONT_SWEEP
  } msif_mode_type;
  // status-clear arming for two-register reads
  typedef enum logic [1:0] {
    MSIF_CLR_IDLE,
    MSIF_CLR_ARMED,
    MSIF_CLR_HALF_A,
    MSIF_CLR_HALF_B
  } msif_clr_type;
  typedef logic signed [11:0] msif_temp_type;
endpackage : msif_pkg

// [hw/msif_temp_if.sv]
`timescale 1ns/10ps
// one temperature channel: sample, limits and flag outputs
interface msif_temp_if;
  logic valid;
  msif_pkg::msif_temp_type value;
  msif_pkg::msif_temp_type high_limit;
  msif_pkg::msif_temp_type low_limit;
  logic [2:0] events;
  modport src (output valid, output value, output high_limit,
    output low_limit, input events);
  modport cmp (input valid, input value, input high_limit,
    input low_limit, output events);
endinterface : msif_temp_if

// [hw/msif_temp_cmp.sv]
`timescale 1ns/10ps
`include "msif_params.svh"
// signed threshold compare for one temperature channel
module msif_temp_cmp
(
  msif_temp_if.cmp t
);
  // ==================================================
  // compare
  // two's complement values, 0.125 degC per lsb
  assign t.events[`MSIF_TF_HIGH] = t.valid &&
    (t.value > t.high_limit);
  assign t.events[`MSIF_TF_LOW] = t.valid &&
    (t.value < t.low_limit);
  assign t.events[`MSIF_TF_NEW] = t.valid;
endmodule : msif_temp_cmp

// [sim/msif_host_model.sv]
`timescale 1ns/10ps
// ==================================================
// host side: one register read per serial transfer
module msif_host_model
(
  input wire logic [2:0] i_op,
  output logic [6:0] o_rd
);
  // op 1 reads flags, ops 2..7 read status lo/hi of three groups
  // status reads count only after a flag read
  // missed and ready bits arrive together in one flag read
  assign o_rd = 7'((8'h01 << i_op) >> 1);
endmodule : msif_host_model

// [sim/msif_flags_chk_sva.sv]
`timescale 1ns/10ps
// ==================================================
// port checker of the flag block
module msif_flags_chk #(
  parameter int PORTS = 12
)
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire msif_pkg::msif_mode_type i_conv_mode,
  input wire logic i_conv_done,
  input wire logic i_sweep_done,
  input wire logic [PORTS-1:0] i_port_sample_done,
  input wire logic [PORTS-1:0] i_port_unread,
  input wire logic i_input_event,
  input wire logic i_supply_low,
  input wire logic [11:0] i_local_temp,
  input wire logic i_local_temp_valid,
  input wire logic [11:0] i_local_high_limit,
  input wire logic i_flags_read,
  input wire logic i_result_status_lo_read,
  input wire logic i_result_status_hi_read,
  input wire logic [15:0] o_event_flags,
  input wire logic [PORTS-1:0] o_result_port_status
);
  // causes of the conversion flag, sample strobes, quiet cycles
  wire logic conv_hit = i_conv_done &&
    i_conv_mode == msif_pkg::MSIF_SINGLE_CONV || i_sweep_done &&
    i_conv_mode >= msif_pkg::MSIF_SINGLE_SWEEP;
  // a port result refreshes only on the completion strobe
  wire logic sampled = |i_port_sample_done && conv_hit;
  wire logic quiet = !i_flags_read && !(|i_port_sample_done);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  sequence s_res_pair;
    i_flags_read ##1 quiet && i_result_status_lo_read
      ##1 quiet && i_result_status_hi_read;
  endsequence
  a_conv_sets: assert property (
    conv_hit |=> o_event_flags[0]) else $error("conversion flag missing");
  a_idle_quiet: assert property (
    i_conv_mode == msif_pkg::MSIF_IDLE && !o_event_flags[0]
    |=> !o_event_flags[0]) else $error("idle mode set conversion flag");
  a_read_clears: assert property (
    i_flags_read && !conv_hit |=> !o_event_flags[0])
    else $error("flag read left conversion flag");
  a_sample_sets: assert property (
    sampled |=> o_event_flags[1] && (o_result_port_status &
    $past(i_port_sample_done)) == $past(i_port_sample_done))
    else $error("sample did not set ready or status");
  a_miss_sets: assert property (
    sampled && |(i_port_sample_done & i_port_unread)
    |=> o_event_flags[2]) else $error("missed result not flagged");
  a_pair_clears: assert property (
    s_res_pair |=> !o_event_flags[1] && o_result_port_status == '0)
    else $error("status pair did not clear ready");
  a_supply_sets: assert property (
    $rose(i_supply_low) |-> ##3 o_event_flags[15])
    else $error("supply low not flagged");
  a_temp_high: assert property (
    i_local_temp_valid && $signed(i_local_temp) >
    $signed(i_local_high_limit) |=> o_event_flags[8])
    else $error("local high limit not flagged");
  a_set_wins: assert property (
    i_flags_read && i_input_event |=> o_event_flags[3])
    else $error("event lost to same cycle read");
endmodule : msif_flags_chk
bind msif_irq_flags msif_flags_chk #(.PORTS(PORTS)) u_chk (.*);

// [sim/tb.sv]
`timescale 1ns/10ps
`include "msif_params.svh"
// ==================================================
// random bench with a cycle model of flags and status
module tb;
  logic i_clk_sys = 1'b0, i_rstn = 1'b0;
  msif_pkg::msif_mode_type i_conv_mode;
  logic i_conv_done, i_sweep_done, i_input_event, i_input_status_overwrite;
  logic i_overcurrent_trip = 1'b0, i_supply_low = 1'b0;
  logic i_local_temp_valid, i_remote_a_valid, i_remote_b_valid;
  logic [11:0] i_port_sample_done, i_port_unread, i_local_temp, st;
  logic [11:0] i_remote_a_temp, i_remote_b_temp, o_result_port_status;
  logic [11:0] i_local_high_limit, i_local_low_limit, i_remote_b_low_limit;
  logic [11:0] i_remote_a_high_limit, i_remote_a_low_limit;
  logic [11:0] i_remote_b_high_limit;
  logic i_flags_read, i_result_status_lo_read, i_result_status_hi_read;
  logic i_input_status_lo_read, i_input_status_hi_read;
  logic i_ocur_status_lo_read, i_ocur_status_hi_read;
  logic [15:0] o_event_flags, o_part_identification, ef;
  logic [6:0] rd;
  logic [2:0] op, s_oc, s_sp;
  logic [31:0] r;
  int arm[3], lo[3], hi[3];
  int err_total = 0;
  int n_checks = 0;
  int seed = 32'h987E96F3;
  // ==================================================
  // clock, host and design
  always #10 i_clk_sys = ~i_clk_sys;
  assign {i_ocur_status_hi_read, i_ocur_status_lo_read,
    i_input_status_hi_read, i_input_status_lo_read, i_result_status_hi_read,
    i_result_status_lo_read, i_flags_read} = rd;
  msif_host_model host (.i_op(op), .o_rd(rd));
  msif_irq_flags dut (.*);
  // ==================================================
  // model helpers
  function automatic logic [2:0] tf(logic signed [11:0] t, h, l, logic v);
    return v ? {t > h, t < l, 1'b1} : 3'h0;
  endfunction : tf
  // one clock edge of the flag model
  task automatic mdl;
    logic [15:0] set, clr;
    logic [11:0] sc;
    logic [11:0] rf;
    set[0] = i_conv_done && i_conv_mode == msif_pkg::MSIF_SINGLE_CONV ||
      i_sweep_done && i_conv_mode >= msif_pkg::MSIF_SINGLE_SWEEP;
    // results refresh only at a conversion or sweep completion
    rf = i_port_sample_done & {12{set[0]}};
    set[1] = |rf;
    set[2] = |(rf & i_port_unread);
    set[5:3] = {s_oc[1] & ~s_oc[2], i_input_status_overwrite, i_input_event};
    set[8:6] = tf(i_local_temp, i_local_high_limit, i_local_low_limit,
      i_local_temp_valid);
    set[11:9] = tf(i_remote_a_temp, i_remote_a_high_limit,
      i_remote_a_low_limit, i_remote_a_valid);
    set[14:12] = tf(i_remote_b_temp, i_remote_b_high_limit,
      i_remote_b_low_limit, i_remote_b_valid);
    set[15] = s_sp[1] & ~s_sp[2];
    clr = i_flags_read ? 16'hFFC5 : 16'h0000;
    sc = 12'h000;
    for (int g = 0; g < 3; g++)
    begin
      lo[g] = i_flags_read ? 0 : lo[g] | (arm[g] & rd[2 * g + 1]);
      hi[g] = i_flags_read ? 0 : hi[g] | (arm[g] & rd[2 * g + 2]);
      arm[g] = i_flags_read ? 1 : arm[g];
      if (lo[g] != 0 && hi[g] != 0)
      begin
        arm[g] = 0;
        lo[g] = 0;
        hi[g] = 0;
        clr |= g == 0 ? 16'h0002 : (g == 1 ? 16'h0018 : 16'h0020);
        sc = g == 0 ? 12'hFFF : sc;
      end
    end
    ef = (ef & ~clr) | set;
    st = (st & ~sc) | rf;
    s_oc = {s_oc[1:0], i_overcurrent_trip};
    s_sp = {s_sp[1:0], i_supply_low};
  endtask : mdl
  // random inputs, sample strobes only outside idle mode
  task drv;
    r = $random(seed);
    i_conv_mode <= msif_pkg::msif_mode_type'(r[1:0]);
    {i_conv_done, i_sweep_done} <= {r[4:2] == 3'h0, r[7:5] == 3'h0};
    i_port_sample_done <= (r[1:0] != 2'h0 && r[10:8] == 3'h0) ?
      12'($random(seed)) : 12'h000;
    i_port_unread <= 12'($random(seed));
    i_input_event <= r[13:11] == 3'h0;
    i_input_status_overwrite <= r[16:14] == 3'h0;
    i_overcurrent_trip <= i_overcurrent_trip ^ (r[20:17] == 4'h0);
    i_supply_low <= i_supply_low ^ (r[24:21] == 4'h0);
    {i_local_temp_valid, i_remote_a_valid, i_remote_b_valid} <= r[27:25];
    op <= r[31:29];
    {i_local_temp, i_local_high_limit} <= 24'($random(seed));
    {i_local_low_limit, i_remote_a_temp} <= 24'($random(seed));
    {i_remote_a_high_limit, i_remote_a_low_limit} <= 24'($random(seed));
    {i_remote_b_temp, i_remote_b_high_limit} <= 24'($random(seed));
    i_remote_b_low_limit <= 12'($random(seed));
  endtask : drv
  // masked compare with report
  task chk(string n, logic [15:0] m, logic [15:0] e, logic [15:0] s);
    n_checks++;
    if ((s & m) !== (e & m))
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e & m, s & m);
    end
  endtask : chk
  // one cycle: model, new stimulus, then compare
  task tick(input logic nr);
    @(posedge i_clk_sys);
    if (i_rstn)
      mdl();
    drv();
    i_rstn <= nr;
    #1;
    if (!i_rstn)
    begin
      {ef, st, s_oc, s_sp} = '0;
      arm = '{0, 0, 0};
      lo = '{0, 0, 0};
      hi = '{0, 0, 0};
    end
    chk("adc", 16'h0007, ef, o_event_flags);
    chk("gpi_ocur", 16'h0038, ef, o_event_flags);
    chk("temp", 16'h7FC0, ef, o_event_flags);
    chk("supply", 16'h8000, ef, o_event_flags);
    chk("status", 16'h0FFF, {4'h0, st}, {4'h0, o_result_port_status});
    chk("id", 16'hFFFF, `MSIF_PART_ID, o_part_identification);
  endtask : tick
  // verdict and end of run
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  // ==================================================
  // main sequence with a second reset mid-run
  initial
  begin
    drv();
    for (int i = 0; i < 4000; i++)
      tick(!(i < 6 || (i >= 2000 && i < 2003)));
    end_of_test();
  end
  // watchdog
  initial
  begin
    #200000;
    err_total++;
    end_of_test();
  end
endmodule : tb
